/* File: core/tcc_defs.svh */
// Purpose: Offsets, field positions and reset values for the capture/compare unit
// Assumes: Byte-wide registers, one per aligned Wishbone word
// Notes: Included by the core, the port checker and the bench
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

`define TCC_OFS_CTRL1 6'h00
`define TCC_OFS_CTRL2 6'h04
`define TCC_OFS_STATUS 6'h08
`define TCC_OFS_CAP1H 6'h0C
`define TCC_OFS_CAP1L 6'h10
`define TCC_OFS_CAP2H 6'h14
`define TCC_OFS_CAP2L 6'h18
`define TCC_OFS_CMP1H 6'h1C
`define TCC_OFS_CMP1L 6'h20
`define TCC_OFS_CMP2H 6'h24
`define TCC_OFS_CMP2L 6'h28
`define TCC_OFS_COUNTH 6'h2C
`define TCC_OFS_COUNTL 6'h30

// control_one fields
`define TCC_C1_CAPIE 7
`define TCC_C1_CMPIE 6
`define TCC_C1_OVFIE 5
`define TCC_C1_FORCE2 4
`define TCC_C1_FORCE1 3
`define TCC_C1_EDGE1 2
`define TCC_C1_LVL2 1
`define TCC_C1_LVL1 0
// control_two fields
`define TCC_C2_OE1 7
`define TCC_C2_OE2 6
`define TCC_C2_ONE_PULSE 5
`define TCC_C2_PWM 4
`define TCC_C2_CS_HI 3
`define TCC_C2_CS_LO 2
`define TCC_C2_EDGE2 1
`define TCC_C2_EXEDGE 0
// timer_status_reg fields
`define TCC_ST_CAPF1 7
`define TCC_ST_CMPF1 6
`define TCC_ST_OVF 5
`define TCC_ST_CAPF2 4
`define TCC_ST_CMPF2 3

`define TCC_CMP_RESET 16'h8000
`define TCC_CNT_RESET 16'hFFFC
`define TCC_CNT_ONE 16'h0001
`define TCC_CNT_MAX 16'hFFFF
`define TCC_PIN_IDLE 2'b11
`define TCC_OE_N_OFF 2'b11
`define TCC_CS_DIV2 2'b00
`define TCC_CS_DIV4 2'b01
`define TCC_CS_DIV8 2'b10
`define TCC_CS_EXT 2'b11

`endif

/* File: core/tcc_pkg.sv */
// Purpose: Types of the capture/compare unit
// Assumes: Nothing beyond the defs header
// Notes: Whole state travels as one packed struct
package tcc_pkg;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [15:0] count;
    logic [2:0] presc;
    logic [1:0] ext_sh;
    logic [15:0] cap1;
    logic [15:0] cap2;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic [1:0] cap_prev;
    logic [1:0] cap_lock;
    logic [1:0] cmp_inhibit;
    logic [1:0] capf;
    logic [1:0] cmpf;
    logic ovf;
    logic [1:0] capf_seen;
    logic [1:0] cmpf_seen;
    logic ovf_seen;
    logic [1:0] pin;
    logic [1:0] oe_n;
    logic one_pulse_out;
    logic tick_d;
    logic irq;
    logic ack;
    logic [7:0] rdata;
  } tcc_state_t;

endpackage

/* File: core/tcc_core.sv */
// Purpose: Capture and compare section of a 16-bit free-running timer
// Assumes: One clock, synchronous active high reset, classic Wishbone slave
// Notes: Byte registers in the low data lane; ack one cycle after the request
`include "tcc_defs.svh"

// How it works
// (R1) Clock select 11 counts from the external count pin.
// (R2) External edge select picks which pin edge advances the counter.
// (R3) External pin is resampled on internal clock before counting.
// (R4) External edges must be four or more CPU clocks apart.
// (R5) Capture pin transition latches counter into that channel's capture value.
// (R6) Capture registers are read-only; writes change nothing.
// (R7) Each channel's capture edge comes from its own control register bit.
// (R8) Capture sets the flag; interrupt when enabled and CPU mask clear.
// (R9) Capture flag clears after status read then low byte access.
// (R10) Reading capture high byte blocks capture until low byte read.
// (R11) Capture value holds the newest capture, overwriting older ones.
// (R12) In one-pulse or PWM only channel 2 captures.
// (R13) Capture pins always feed capture logic, any transition counts; the core counts only the edge selected per channel (R7).
// (R14) Compare values are checked against the counter each timer clock.
// (R15) Compare values are software-only registers, reset to 8000h.
// (R16) Match sets compare flag and drives level; pin low at reset.
// (R17) Compare flag clears after status read then low byte access.
// (R18) Writing compare high byte inhibits compare until low byte written.
// (R19) Output enable clear: pin untouched, interrupt still possible; the core still lets force level change the pin.
// (R20) Divide by 2 matches on equal, other clocks on value plus one.
// (R21) Force level copies level to pin without flag; not in one-pulse or PWM.
// (R22) One-pulse select enters one-pulse mode on channel one.
// (R23) Internal timer clock is CPU clock divided by 2, 4 or 8.
// (R24) PWM and one-pulse both set means PWM only.
// (R25) All requests merge into one interrupt output.
// (R26) Software should write high byte, read status, write low byte.
module tcc_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cpu_mask_i,
  input wire logic ext_count_pin_i,
  input wire logic [1:0] capture_input_pin_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [1:0] compare_output_pin_o,
  output logic [1:0] compare_output_oe_n_o,
  output logic one_pulse_mode_o,
  output logic timer_irq_o
);

  tcc_pkg::tcc_state_t s_reg;
  tcc_pkg::tcc_state_t s_next;

  logic req;
  logic wr;
  logic rd;
  logic [1:0] cs;
  logic pwm_on;
  logic one_pulse_on;
  logic ext_edge;
  logic tick;
  logic [1:0] cap_edge_sel;
  logic [1:0] cap_evt;
  logic [1:0] cmp_hit;
  logic [15:0] cmp_target [2];
  logic [7:0] status;
  logic [7:0] rd_mux;

  always_comb begin
    req = wb_cyc_i && wb_stb_i && !s_reg.ack;
    wr = req && wb_we_i && wb_sel_i[0];
    rd = req && !wb_we_i;
    cs = s_reg.ctrl2[`TCC_C2_CS_HI:`TCC_C2_CS_LO];
    pwm_on = s_reg.ctrl2[`TCC_C2_PWM];
    one_pulse_on = s_reg.ctrl2[`TCC_C2_ONE_PULSE] && !pwm_on; // R22 R24
    // Edge on the resampled pin, polarity from ext_edge_select
    ext_edge = s_reg.ctrl2[`TCC_C2_EXEDGE] ? (s_reg.ext_sh[0] && !s_reg.ext_sh[1])
                                            : (!s_reg.ext_sh[0] && s_reg.ext_sh[1]); // R2 R3
    case (cs)
      `TCC_CS_DIV2: tick = s_reg.presc[0]; // R23
      `TCC_CS_DIV4: tick = &s_reg.presc[1:0]; // R23
      `TCC_CS_DIV8: tick = &s_reg.presc; // R23
      default: tick = ext_edge; // R1 R4
    endcase
    cap_edge_sel = {s_reg.ctrl2[`TCC_C2_EDGE2], s_reg.ctrl1[`TCC_C1_EDGE1]}; // R7
    for (int i = 0; i < 2; i++) begin
      // Pins feed capture logic unconditionally
      cap_evt[i] = cap_edge_sel[i] ? (capture_input_pin_i[i] && !s_reg.cap_prev[i])
                                   : (!capture_input_pin_i[i] && s_reg.cap_prev[i]); // R13
    end
    cap_evt[0] = cap_evt[0] && !pwm_on && !one_pulse_on; // R12
    // Slow clocks see the match one count late
    cmp_target[0] = (cs == `TCC_CS_DIV2) ? s_reg.cmp1 : s_reg.cmp1 + `TCC_CNT_ONE; // R20
    cmp_target[1] = (cs == `TCC_CS_DIV2) ? s_reg.cmp2 : s_reg.cmp2 + `TCC_CNT_ONE; // R20
    for (int i = 0; i < 2; i++) begin
      // Flag once on the first timer clock of the matching count
      cmp_hit[i] = s_reg.tick_d && (s_reg.count == cmp_target[i]) &&
                   !s_reg.cmp_inhibit[i]; // R14 R18
    end
    status = 8'h00;
    status[`TCC_ST_CAPF1] = s_reg.capf[0];
    status[`TCC_ST_CAPF2] = s_reg.capf[1];
    status[`TCC_ST_CMPF1] = s_reg.cmpf[0];
    status[`TCC_ST_CMPF2] = s_reg.cmpf[1];
    status[`TCC_ST_OVF] = s_reg.ovf;
    if (wb_adr_i == `TCC_OFS_CTRL1) begin
      rd_mux = s_reg.ctrl1;
    end else if (wb_adr_i == `TCC_OFS_CTRL2) begin
      rd_mux = s_reg.ctrl2;
    end else if (wb_adr_i == `TCC_OFS_STATUS) begin
      rd_mux = status;
    end else if (wb_adr_i == `TCC_OFS_CAP1H) begin
      rd_mux = s_reg.cap1[15:8];
    end else if (wb_adr_i == `TCC_OFS_CAP1L) begin
      rd_mux = s_reg.cap1[7:0];
    end else if (wb_adr_i == `TCC_OFS_CAP2H) begin
      rd_mux = s_reg.cap2[15:8];
    end else if (wb_adr_i == `TCC_OFS_CAP2L) begin
      rd_mux = s_reg.cap2[7:0];
    end else if (wb_adr_i == `TCC_OFS_CMP1H) begin
      rd_mux = s_reg.cmp1[15:8];
    end else if (wb_adr_i == `TCC_OFS_CMP1L) begin
      rd_mux = s_reg.cmp1[7:0];
    end else if (wb_adr_i == `TCC_OFS_CMP2H) begin
      rd_mux = s_reg.cmp2[15:8];
    end else if (wb_adr_i == `TCC_OFS_CMP2L) begin
      rd_mux = s_reg.cmp2[7:0];
    end else if (wb_adr_i == `TCC_OFS_COUNTH) begin
      rd_mux = s_reg.count[15:8];
    end else if (wb_adr_i == `TCC_OFS_COUNTL) begin
      rd_mux = s_reg.count[7:0];
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.ack = req;
    s_next.rdata = rd ? rd_mux : s_reg.rdata;
    s_next.presc = s_reg.presc + 3'd1;
    s_next.ext_sh = {s_reg.ext_sh[0], ext_count_pin_i}; // R3
    s_next.cap_prev = capture_input_pin_i;
    s_next.tick_d = tick;
    if (tick) begin
      s_next.count = s_reg.count + `TCC_CNT_ONE;
    end
    // Status read arms the clear for flags set at that moment
    if (rd && (wb_adr_i == `TCC_OFS_STATUS)) begin
      s_next.capf_seen = s_reg.capf; // R9
      s_next.cmpf_seen = s_reg.cmpf; // R17
      s_next.ovf_seen = s_reg.ovf;
    end
    if (req && (wb_adr_i == `TCC_OFS_COUNTL)) begin
      if (s_reg.ovf_seen) begin
        s_next.ovf = 1'b0;
      end
      s_next.ovf_seen = 1'b0;
      if (wr) begin
        s_next.count = `TCC_CNT_RESET;
      end
    end
    // Rollover after the clear so a same-cycle set wins
    if (tick && (s_reg.count == `TCC_CNT_MAX)) begin
      s_next.ovf = 1'b1;
    end
    if (wr && (wb_adr_i == `TCC_OFS_CTRL1)) begin
      s_next.ctrl1 = wb_dat_i[7:0];
    end
    if (wr && (wb_adr_i == `TCC_OFS_CTRL2)) begin
      s_next.ctrl2 = wb_dat_i[7:0];
    end
    // Capture registers ignore writes
    if (rd && (wb_adr_i == `TCC_OFS_CAP1H)) begin
      s_next.cap_lock[0] = 1'b1; // R6 R10
    end
    if (rd && (wb_adr_i == `TCC_OFS_CAP2H)) begin
      s_next.cap_lock[1] = 1'b1; // R10
    end
    if (rd && (wb_adr_i == `TCC_OFS_CAP1L)) begin
      s_next.cap_lock[0] = 1'b0; // R10
    end
    if (rd && (wb_adr_i == `TCC_OFS_CAP2L)) begin
      s_next.cap_lock[1] = 1'b0; // R10
    end
    if (req && (wb_adr_i == `TCC_OFS_CAP1L)) begin
      if (s_reg.capf_seen[0]) begin
        s_next.capf[0] = 1'b0; // R9
      end
      s_next.capf_seen[0] = 1'b0;
    end
    if (req && (wb_adr_i == `TCC_OFS_CAP2L)) begin
      if (s_reg.capf_seen[1]) begin
        s_next.capf[1] = 1'b0; // R9
      end
      s_next.capf_seen[1] = 1'b0;
    end
    if (wr && (wb_adr_i == `TCC_OFS_CMP1H)) begin
      s_next.cmp1[15:8] = wb_dat_i[7:0]; // R15
      s_next.cmp_inhibit[0] = 1'b1; // R18 R26
    end
    if (wr && (wb_adr_i == `TCC_OFS_CMP2H)) begin
      s_next.cmp2[15:8] = wb_dat_i[7:0]; // R15
      s_next.cmp_inhibit[1] = 1'b1; // R18
    end
    if (wr && (wb_adr_i == `TCC_OFS_CMP1L)) begin
      s_next.cmp1[7:0] = wb_dat_i[7:0]; // R15
      s_next.cmp_inhibit[0] = 1'b0; // R18
    end
    if (wr && (wb_adr_i == `TCC_OFS_CMP2L)) begin
      s_next.cmp2[7:0] = wb_dat_i[7:0]; // R15
      s_next.cmp_inhibit[1] = 1'b0; // R18
    end
    if (req && (wb_adr_i == `TCC_OFS_CMP1L)) begin
      if (s_reg.cmpf_seen[0]) begin
        s_next.cmpf[0] = 1'b0; // R17
      end
      s_next.cmpf_seen[0] = 1'b0;
    end
    if (req && (wb_adr_i == `TCC_OFS_CMP2L)) begin
      if (s_reg.cmpf_seen[1]) begin
        s_next.cmpf[1] = 1'b0; // R17
      end
      s_next.cmpf_seen[1] = 1'b0;
    end
    // Events after the clears so a same-cycle set wins
    if (cap_evt[0] && !s_reg.cap_lock[0]) begin
      s_next.cap1 = s_reg.count; // R5 R11
      s_next.capf[0] = 1'b1; // R8
    end
    if (cap_evt[1] && !s_reg.cap_lock[1]) begin
      s_next.cap2 = s_reg.count; // R5 R11
      s_next.capf[1] = 1'b1; // R8
    end
    for (int i = 0; i < 2; i++) begin
      if (cmp_hit[i] && !pwm_on && !(one_pulse_on && i == 0)) begin
        s_next.cmpf[i] = 1'b1; // R16 R19
        if (s_reg.ctrl2[`TCC_C2_OE1 - i]) begin
          s_next.pin[i] = s_reg.ctrl1[`TCC_C1_LVL1 + i]; // R16 R19
        end
      end
    end
    // Force level is a one-shot copy, no flag
    if (!pwm_on && !one_pulse_on) begin
      if (s_reg.ctrl1[`TCC_C1_FORCE1]) begin
        s_next.pin[0] = s_reg.ctrl1[`TCC_C1_LVL1]; // R21
      end
      if (s_reg.ctrl1[`TCC_C1_FORCE2]) begin
        s_next.pin[1] = s_reg.ctrl1[`TCC_C1_LVL2]; // R21
      end
    end
    // Dropped in waveform modes too, so no stale force fires on mode exit
    if (s_reg.ctrl1[`TCC_C1_FORCE1]) begin
      s_next.ctrl1[`TCC_C1_FORCE1] = 1'b0; // R21
    end
    if (s_reg.ctrl1[`TCC_C1_FORCE2]) begin
      s_next.ctrl1[`TCC_C1_FORCE2] = 1'b0; // R21
    end
    s_next.irq = ((s_reg.ctrl1[`TCC_C1_CAPIE] && |s_reg.capf) ||
                  (s_reg.ctrl1[`TCC_C1_CMPIE] && |s_reg.cmpf) ||
                  (s_reg.ctrl1[`TCC_C1_OVFIE] && s_reg.ovf)) && !cpu_mask_i; // R8 R16 R25
    s_next.oe_n = ~{s_next.ctrl2[`TCC_C2_OE2], s_next.ctrl2[`TCC_C2_OE1]}; // R19
    s_next.one_pulse_out = s_next.ctrl2[`TCC_C2_ONE_PULSE] &&
                           !s_next.ctrl2[`TCC_C2_PWM]; // R22 R24
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.count <= `TCC_CNT_RESET;
      s_reg.cmp1 <= `TCC_CMP_RESET; // R15
      s_reg.cmp2 <= `TCC_CMP_RESET; // R15
      // Idle-high view of the pins, so a pulled-up input gives no false edge
      s_reg.ext_sh <= `TCC_PIN_IDLE;
      s_reg.cap_prev <= `TCC_PIN_IDLE;
      s_reg.oe_n <= `TCC_OE_N_OFF;
      s_reg.pin <= 2'b00; // R16
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    wb_dat_o = {24'h00_0000, s_reg.rdata};
    wb_ack_o = s_reg.ack;
    compare_output_pin_o = s_reg.pin;
    compare_output_oe_n_o = s_reg.oe_n; // R19
    one_pulse_mode_o = s_reg.one_pulse_out; // R22 R24
    timer_irq_o = s_reg.irq;
  end

endmodule // tcc_core

/* File: tb/tcc_core_properties.sv */
// Purpose: Port checks of the capture/compare core
// Assumes: Classic Wishbone slave, ack one cycle after request
// Notes: Bound into every tcc_core
`include "tcc_defs.svh"
module tcc_core_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cpu_mask_i,
  input wire logic ext_count_pin_i,
  input wire logic [1:0] capture_input_pin_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] compare_output_pin_o,
  input wire logic [1:0] compare_output_oe_n_o,
  input wire logic one_pulse_mode_o,
  input wire logic timer_irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic c2_wr;
  assign c2_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `TCC_OFS_CTRL2;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_timing: assert property (s_req |=> s_answer) else $error("bad ack timing");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_read_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved");
  chk_data_lane: assert property (wb_dat_o[31:8] == 24'h00_0000) else $error("upper lane");
  chk_irq_mask: assert property ($past(cpu_mask_i) |-> !timer_irq_o)
    else $error("irq while masked");
  chk_pin_reset: assert property ($fell(rst_i) |-> compare_output_pin_o == 2'b00 &&
    compare_output_oe_n_o == 2'b11) else $error("pins after reset");
  chk_oe_source: assert property ($changed(compare_output_oe_n_o) |->
    c2_wr || $past(c2_wr) || $past(c2_wr, 2)) else $error("oe changed alone");
  chk_mode_source: assert property ($changed(one_pulse_mode_o) |->
    c2_wr || $past(c2_wr) || $past(c2_wr, 2)) else $error("mode changed alone");
endmodule // tcc_core_chk
bind tcc_core tcc_core_chk tcc_core_chk_inst (.clk_i, .rst_i, .cpu_mask_i, .ext_count_pin_i,
  .capture_input_pin_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .compare_output_pin_o, .compare_output_oe_n_o, .one_pulse_mode_o,
  .timer_irq_o);

/* File: tb/tcc_pins_model.sv */
// Purpose: Drives capture and external count pins
// Assumes: Plain levels sampled on the core clock
// Notes: Levels change right after a rising edge; pins idle high like pulled-up inputs
module tcc_pins_model (
  input wire logic clk_i,
  output logic ext_count_pin_o,
  output logic [1:0] capture_input_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ext_count_pin_o = 1'b1;
    capture_input_pin_o = 2'b11;
  end
  task automatic toggle_cap(input int ch);
    @(posedge clk_i);
    capture_input_pin_o[ch] <= ~capture_input_pin_o[ch];
    repeat (6) @(posedge clk_i);
  endtask
  // One falling and one rising edge per step, seven clocks apart
  task automatic ext_edges(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) begin
        @(posedge clk_i);
        ext_count_pin_o <= ~ext_count_pin_o;
        repeat (6) @(posedge clk_i);
      end
    end
  endtask
endmodule // tcc_pins_model

/* File: tb/timer_capture_compare_unit_test.sv */
// Purpose: Self-checking bench of the capture/compare core
// Assumes: Core acks one cycle after each request
// Notes: Pin stimulus from tcc_pins_model
`include "tcc_defs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t got %h want %h", $time, (a), (b)); end end
module timer_capture_compare_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cpu_mask_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic ext_count_pin_i;
  logic [1:0] capture_input_pin_i;
  logic [1:0] compare_output_pin_o;
  logic [1:0] compare_output_oe_n_o;
  logic one_pulse_mode_o;
  logic timer_irq_o;
  logic [7:0] q;
  logic [7:0] h;
  logic [15:0] c;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  tcc_core tcc_core_inst (.clk_i, .rst_i, .cpu_mask_i, .ext_count_pin_i, .capture_input_pin_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .compare_output_pin_o, .compare_output_oe_n_o, .one_pulse_mode_o, .timer_irq_o);
  tcc_pins_model tcc_pins_model_inst (.clk_i, .ext_count_pin_o(ext_count_pin_i),
    .capture_input_pin_o(capture_input_pin_i));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic summarize();
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    `CHK(wb_dat_o[31:8], 24'h00_0000)
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'h1);
  endtask
  task automatic rd(input logic [5:0] a);
    wb(1'b0, a, 8'h00, 4'h1);
  endtask
  task automatic t_reset_regs();
    rd(`TCC_OFS_CMP1H);
    `CHK(q, 8'h80)
    rd(`TCC_OFS_CMP2L);
    `CHK(q, 8'h00)
    rd(6'h3C);
    `CHK(q, 8'h00)
    wr(`TCC_OFS_CMP2H, 8'h12);
    rd(`TCC_OFS_CMP2H);
    `CHK(q, 8'h12)
    wb(1'b1, `TCC_OFS_CMP2H, 8'h34, 4'hE);
    rd(`TCC_OFS_CMP2H);
    `CHK(q, 8'h12)
  endtask
  task automatic t_capture();
    wr(`TCC_OFS_CTRL1, 8'h04);
    tcc_pins_model_inst.toggle_cap(0);
    rd(`TCC_OFS_STATUS);
    `CHK(q[7], 1'b0)
    tcc_pins_model_inst.toggle_cap(0);
    rd(`TCC_OFS_STATUS);
    `CHK(q[7], 1'b1)
    rd(`TCC_OFS_CAP1H);
    h = q;
    rd(`TCC_OFS_CAP1L);
    c = {h, q};
    rd(`TCC_OFS_STATUS);
    `CHK(q[7], 1'b0)
    wr(`TCC_OFS_CAP1L, ~c[7:0]);
    tcc_pins_model_inst.toggle_cap(0);
    rd(`TCC_OFS_CAP1H);
    tcc_pins_model_inst.toggle_cap(0);
    tcc_pins_model_inst.toggle_cap(0);
    rd(`TCC_OFS_STATUS);
    `CHK(q[7], 1'b0)
    rd(`TCC_OFS_CAP1L);
    `CHK(q, c[7:0])
    tcc_pins_model_inst.toggle_cap(0);
    tcc_pins_model_inst.toggle_cap(0);
    rd(`TCC_OFS_CAP1H);
    h = q;
    rd(`TCC_OFS_CAP1L);
    `CHK(({h, q} != c), 1'b1)
    wr(`TCC_OFS_CTRL2, 8'h02);
    tcc_pins_model_inst.toggle_cap(1);
    rd(`TCC_OFS_STATUS);
    `CHK(q[4], 1'b0)
    tcc_pins_model_inst.toggle_cap(1);
    rd(`TCC_OFS_STATUS);
    `CHK(q[4], 1'b1)
  endtask
  task automatic t_compare();
    wr(`TCC_OFS_CMP1H, 8'h00);
    wr(`TCC_OFS_CTRL1, 8'h41);
    wr(`TCC_OFS_CTRL2, 8'h80);
    `CHK(compare_output_oe_n_o, 2'b10)
    wr(`TCC_OFS_COUNTL, 8'h00);
    repeat (80) @(posedge clk_i);
    rd(`TCC_OFS_STATUS);
    `CHK(q[6], 1'b0)
    wr(`TCC_OFS_CMP1L, 8'h10);
    wr(`TCC_OFS_COUNTL, 8'h00);
    repeat (80) @(posedge clk_i);
    rd(`TCC_OFS_STATUS);
    `CHK(q[6], 1'b1)
    `CHK(compare_output_pin_o[0], 1'b1)
    `CHK(timer_irq_o, 1'b0)
    cpu_mask_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(timer_irq_o, 1'b1)
    rd(`TCC_OFS_CMP1L);
    rd(`TCC_OFS_STATUS);
    `CHK(q[6], 1'b0)
    `CHK(timer_irq_o, 1'b0)
    cpu_mask_i <= 1'b1;
    wr(`TCC_OFS_CTRL2, 8'h00);
    `CHK(compare_output_oe_n_o, 2'b11)
    wr(`TCC_OFS_CTRL1, 8'h40);
    wr(`TCC_OFS_COUNTL, 8'h00);
    repeat (80) @(posedge clk_i);
    `CHK(compare_output_pin_o[0], 1'b1)
    rd(`TCC_OFS_STATUS);
    `CHK(q[6], 1'b1)
  endtask
  task automatic t_force_modes();
    wr(`TCC_OFS_CTRL2, 8'h80);
    rd(`TCC_OFS_CMP1L);
    wr(`TCC_OFS_CTRL1, 8'h08);
    repeat (2) @(posedge clk_i);
    `CHK(compare_output_pin_o[0], 1'b0)
    rd(`TCC_OFS_STATUS);
    `CHK(q[6], 1'b0)
    wr(`TCC_OFS_CTRL2, 8'h20);
    repeat (2) @(posedge clk_i);
    `CHK(one_pulse_mode_o, 1'b1)
    rd(`TCC_OFS_CAP1L);
    rd(`TCC_OFS_CAP2L);
    tcc_pins_model_inst.toggle_cap(0);
    tcc_pins_model_inst.toggle_cap(0);
    tcc_pins_model_inst.toggle_cap(1);
    rd(`TCC_OFS_STATUS);
    `CHK(q[7], 1'b0)
    `CHK(q[4], 1'b1)
    wr(`TCC_OFS_CTRL2, 8'h30);
    repeat (2) @(posedge clk_i);
    `CHK(one_pulse_mode_o, 1'b0)
  endtask
  task automatic t_ext_clock(input logic [7:0] c2, input int n, input logic [15:0] want);
    wr(`TCC_OFS_CTRL2, c2);
    wr(`TCC_OFS_COUNTL, 8'h00);
    tcc_pins_model_inst.ext_edges(n);
    rd(`TCC_OFS_COUNTH);
    `CHK(q, want[15:8])
    rd(`TCC_OFS_COUNTL);
    `CHK(q, want[7:0])
  endtask
  task automatic t_ext_compare();
    wr(`TCC_OFS_CMP1H, 8'h00);
    rd(`TCC_OFS_STATUS);
    wr(`TCC_OFS_CMP1L, 8'h02);
    wr(`TCC_OFS_CTRL2, 8'h0D);
    wr(`TCC_OFS_COUNTL, 8'h00);
    tcc_pins_model_inst.ext_edges(6);
    rd(`TCC_OFS_STATUS);
    `CHK(q[6], 1'b0)
    tcc_pins_model_inst.ext_edges(1);
    rd(`TCC_OFS_STATUS);
    `CHK(q[6], 1'b1)
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_regs();
    t_capture();
    t_compare();
    t_force_modes();
    t_ext_clock(8'h0D, 8, 16'h0004);
    t_ext_clock(8'h0C, 3, 16'hFFFF);
    t_ext_compare();
    summarize();
  end
endmodule // timer_capture_compare_unit_test
